/* include/acdrv_defs.svh */
// Constants of the actuator driver control logic.
// Assumes a 25 MHz core clock; all times are turned into cycles here.
`ifndef ACDRV_DEFS_SVH
`define ACDRV_DEFS_SVH

// ----------------------------------------------------------------------------
// Sizes
// ----------------------------------------------------------------------------
`define ACDRV_NDRV 8
`define ACDRV_NHB 2
`define ACDRV_NPWM 4
`define ACDRV_NFLT 21
`define ACDRV_NRAW 23
`define ACDRV_CNT_W 16

// ----------------------------------------------------------------------------
// Filter and raw vector positions
// ----------------------------------------------------------------------------
`define ACDRV_F_PUMP 0
`define ACDRV_F_OV 1
`define ACDRV_F_UV 2
`define ACDRV_F_TW 3
`define ACDRV_F_TSD 4
`define ACDRV_F_OC 5
`define ACDRV_F_OL 13
`define ACDRV_R_VCCLO 21
`define ACDRV_R_VCCHI 22

// ----------------------------------------------------------------------------
// Times
// ----------------------------------------------------------------------------
`define ACDRV_CLK_HZ 25000000
`define ACDRV_US2CYC(t) ((t) * (`ACDRV_CLK_HZ / 1000000))
`define ACDRV_WAKE_US 10
`define ACDRV_STANDBY_US 256
`define ACDRV_OC_FILT_US 2
`define ACDRV_OL_FILT_US 100
`define ACDRV_SUP_FILT_US 20
`define ACDRV_TEMP_FILT_US 20
`define ACDRV_PUMP_LIM_US 50
`define ACDRV_CROSS_US 2
`define ACDRV_BLANK_US 20
`define ACDRV_OCREC_ON_US 10
`define ACDRV_PWM_LO_HZ 122
`define ACDRV_PWM_HI_HZ 244
`define ACDRV_PWM_STEPS 128
`define ACDRV_PWM_LO_STEP (`ACDRV_CLK_HZ / (`ACDRV_PWM_LO_HZ * `ACDRV_PWM_STEPS))
`define ACDRV_PWM_HI_STEP (`ACDRV_CLK_HZ / (`ACDRV_PWM_HI_HZ * `ACDRV_PWM_STEPS))
`define ACDRV_OCREC_OFF12 7
`define ACDRV_OCREC_OFF25 3

// ----------------------------------------------------------------------------
// Serial commands
// ----------------------------------------------------------------------------
`define ACDRV_CMD_SWRESET 8'hFF
`define ACDRV_CMD_RDCLR 2'h3

`endif

/* include/acdrv_pkg.sv */
// Types shared by the actuator driver control logic.
// Assumes acdrv_defs.svh is on the include path.
`include "acdrv_defs.svh"

package acdrv_pkg;

    typedef enum logic [1:0] {ST_STANDBY, ST_WAKE, ST_ACTIVE} acdrv_mode_type;

    typedef struct packed {
        logic pump_low;
        logic vs_ov;
        logic vs_uv;
        logic temp_warn;
        logic temp_shut;
        logic [`ACDRV_NDRV-1:0] oc;
        logic [`ACDRV_NDRV-1:0] ol;
    } acdrv_status_type;

    typedef struct packed {
        logic pump_en;
        logic mirror_en;
        logic gate_sink;
        logic gate_resistive;
        logic outputs_hiz;
    } acdrv_supply_ctl_type;

endpackage

/* rtl/acdrv_core.sv */
// Control and protection logic of a multi-output actuator driver.
// Assumes analog conditions and serial pins arrive asynchronously; control bits on mclk_i.
// How it works
// - Standby after power up; chip-select falling wakes analog part.
// - Without enable, standby returns 256 us after chip-select rises; latches cleared.
// - Pump low too long: outputs and mirror off, gates resistive, flag set.
// - Pump-low flag cleared by software reset command or when an over/undervoltage ends.
// - Each condition must persist its filter time before its flag sets.
// - Open load and warning only report; overcurrent, shutdown disable drivers.
// - Filtered overcurrent latches flag, driver off until host clears it.
// - Overvoltage: outputs high impedance, pump stopped, gates sink.
// - Undervoltage: outputs off, pump kept running; on return pump flag clears.
// - Recovery-disable bit keeps drivers off until host clears flags.
// - Logic supply low or high: outputs off, all flags cleared.
// - Warning flag after filter; shutdown flag switches all stages off.
// - Thermal flags latch; any read-and-clear command clears them.
// - After clearing, shutdown needs warning then shutdown filter again.
// - Enabled output with low current for filter time sets open-load.
// - Four-bit select picks monitored output; blanked, off when output off.
// - PWM enable: drive is PWM waveform AND output on bit.
// - One setting selects common PWM rate of 122 Hz or 244 Hz.
// - Four 7-bit duties, step one 128th, maximum full period minus step.
// - Half-bridge partner waits cross delay; off side then turns off fast.
// - With recovery bit, overcurrent output retries at 12 or 25 percent duty.
`timescale 1ns/1ps
`include "acdrv_defs.svh"

module acdrv_core
    import acdrv_pkg::*;
#(
    parameter int STANDBY_CYC = `ACDRV_US2CYC(`ACDRV_STANDBY_US),
    parameter int OL_FILT_CYC = `ACDRV_US2CYC(`ACDRV_OL_FILT_US)
)
(
    input wire logic mclk_i,
    input wire logic reset_i,
    input wire logic ce_i,
    input wire logic sclk_i,
    input wire logic cs_n_i,
    input wire logic sdi_i,
    input wire logic enable_i,
    input wire logic supply_fault_recovery_disable_i,
    input wire logic [`ACDRV_NDRV-1:0] on_i,
    input wire logic [`ACDRV_NDRV-1:0] pwm_en_i,
    input wire logic [`ACDRV_NDRV-1:0] oc_recovery_i,
    input wire logic oc_duty25_i,
    input wire logic pwm_fast_i,
    input wire logic [`ACDRV_NPWM-1:0][6:0] duty_i,
    input wire logic [3:0] current_monitor_select_i,
    input wire logic pump_low_i,
    input wire logic vs_ov_i,
    input wire logic vs_uv_i,
    input wire logic temp_warn_i,
    input wire logic temp_shut_i,
    input wire logic vcc_low_i,
    input wire logic vcc_high_i,
    input wire logic [`ACDRV_NDRV-1:0] oc_i,
    input wire logic [`ACDRV_NDRV-1:0] ol_i,
    output logic active_o,
    output logic [`ACDRV_NDRV-1:0] drive_o,
    output logic [2*`ACDRV_NHB-1:0] fast_off_o,
    output acdrv_supply_ctl_type supply_ctl_o,
    output acdrv_status_type status_o,
    output logic current_monitor_output_o,
    output logic [3:0] current_monitor_source_o
);

    // ------------------------------------------------------------------------
    // Link side: command byte shifted in on the serial clock
    // ------------------------------------------------------------------------
    logic [7:0] shift;
    logic [3:0] bit_cnt;
    logic [7:0] cmd_word;
    logic word_ok;

    // Bit counter is ended by the frame itself
    always_ff @(posedge sclk_i or posedge cs_n_i)
    begin
        if (cs_n_i)
            bit_cnt <= 4'h0;
        else if (bit_cnt != 4'h8)
            bit_cnt <= bit_cnt + 4'h1;
    end

    // Word and flag stay still while chip select is high
    always_ff @(posedge sclk_i)
    begin
        shift <= {shift[6:0], sdi_i};
        if (bit_cnt == 4'h7)
        begin
            cmd_word <= {shift[6:0], sdi_i};
            word_ok <= 1'b1;
        end
        else if (bit_cnt == 4'h0)
            word_ok <= 1'b0;
    end

    // ------------------------------------------------------------------------
    // Synchronisers
    // ------------------------------------------------------------------------
    logic [2:0] cs_sync;
    logic [`ACDRV_NRAW-1:0] raw_meta;
    logic [`ACDRV_NRAW-1:0] raw_sync;
    logic cs_fall;
    logic cs_rise;

    always_ff @(posedge mclk_i)
    begin
        if (reset_i)
        begin
            cs_sync <= 3'h7;
            raw_meta <= '0;
            raw_sync <= '0;
        end
        else if (ce_i)
        begin
            cs_sync <= {cs_sync[1:0], cs_n_i};
            raw_meta <= {vcc_high_i, vcc_low_i, ol_i, oc_i, temp_shut_i, temp_warn_i,
                         vs_uv_i, vs_ov_i, pump_low_i};
            raw_sync <= raw_meta;
        end
    end

    assign cs_fall = cs_sync[2] & ~cs_sync[1];
    assign cs_rise = ~cs_sync[2] & cs_sync[1];

    // ------------------------------------------------------------------------
    // Diagnostic filters
    // ------------------------------------------------------------------------
    acdrv_status_type st;
    acdrv_status_type next_st;
    acdrv_mode_type mode;
    acdrv_mode_type next_mode;
    logic [`ACDRV_NFLT-1:0] cond;
    logic [`ACDRV_NFLT-1:0] filt;
    logic hold;
    logic ov_live;
    logic uv_live;

    assign hold = raw_sync[`ACDRV_R_VCCLO] | raw_sync[`ACDRV_R_VCCHI];
    assign ov_live = filt[`ACDRV_F_OV];
    assign uv_live = filt[`ACDRV_F_UV];

    function automatic logic [`ACDRV_CNT_W-1:0] flt_limit(input int idx);
        int cyc;
        if (idx == `ACDRV_F_PUMP)
            cyc = `ACDRV_US2CYC(`ACDRV_PUMP_LIM_US);
        else if (idx == `ACDRV_F_OV || idx == `ACDRV_F_UV)
            cyc = `ACDRV_US2CYC(`ACDRV_SUP_FILT_US);
        else if (idx == `ACDRV_F_TW || idx == `ACDRV_F_TSD)
            cyc = `ACDRV_US2CYC(`ACDRV_TEMP_FILT_US);
        else if (idx < `ACDRV_F_OL)
            cyc = `ACDRV_US2CYC(`ACDRV_OC_FILT_US);
        else
            cyc = OL_FILT_CYC;
        return cyc[`ACDRV_CNT_W-1:0];
    endfunction

    always_comb
    begin
        cond = raw_sync[`ACDRV_NFLT-1:0];
        cond[`ACDRV_F_PUMP] = raw_sync[`ACDRV_F_PUMP] & supply_ctl_o.pump_en;
        cond[`ACDRV_F_TSD] = raw_sync[`ACDRV_F_TSD] & st.temp_warn;
        for (int i = 0; i < `ACDRV_NDRV; i++)
        begin
            cond[`ACDRV_F_OC + i] = raw_sync[`ACDRV_F_OC + i] & drive_o[i];
            cond[`ACDRV_F_OL + i] = raw_sync[`ACDRV_F_OL + i] & drive_o[i];
        end
    end

    for (genvar g = 0; g < `ACDRV_NFLT; g++)
    begin : g_flt
        logic [`ACDRV_CNT_W-1:0] cnt;
        logic [`ACDRV_CNT_W-1:0] next_cnt;
        logic hit;
        logic next_hit;

        // Glitch shorter than the limit restarts the count
        always_comb
        begin
            next_cnt = cnt;
            next_hit = hit;
            if (!cond[g] || mode == ST_STANDBY)
            begin
                next_cnt = '0;
                next_hit = 1'b0;
            end
            else if (cnt >= flt_limit(g) - `ACDRV_CNT_W'(1))
                next_hit = 1'b1;
            else
                next_cnt = cnt + `ACDRV_CNT_W'(1);
        end

        always_ff @(posedge mclk_i)
        begin
            if (reset_i)
            begin
                cnt <= '0;
                hit <= 1'b0;
            end
            else if (ce_i)
            begin
                cnt <= next_cnt;
                hit <= next_hit;
            end
        end

        assign filt[g] = hit;
    end

    // ------------------------------------------------------------------------
    // Mode and status flags
    // ------------------------------------------------------------------------
    logic [`ACDRV_CNT_W-1:0] stby_cnt;
    logic [`ACDRV_CNT_W-1:0] next_stby_cnt;
    logic sup_prev;
    logic wipe;
    logic clr_rc;
    logic clr_all;
    logic sup_back;

    always_comb
    begin
        next_mode = mode;
        next_stby_cnt = '0;
        wipe = hold;
        clr_rc = 1'b0;
        clr_all = 1'b0;
        unique case (mode)
            ST_STANDBY:
                if (cs_fall)
                    next_mode = ST_WAKE;
            ST_WAKE:
                if (enable_i)
                    next_mode = ST_ACTIVE;
                else if (cs_sync[2])
                begin
                    next_stby_cnt = stby_cnt + `ACDRV_CNT_W'(1);
                    if (stby_cnt >= STANDBY_CYC[`ACDRV_CNT_W-1:0] - `ACDRV_CNT_W'(1))
                    begin
                        next_mode = ST_STANDBY;
                        wipe = 1'b1;
                    end
                end
            ST_ACTIVE:
                if (!enable_i)
                    next_mode = ST_WAKE;
        endcase
        if (raw_sync[`ACDRV_R_VCCHI])
            next_mode = ST_STANDBY;
        if (cs_rise && mode != ST_STANDBY && word_ok)
        begin
            if (cmd_word == `ACDRV_CMD_SWRESET)
                clr_all = 1'b1;
            else if (cmd_word[7:6] == `ACDRV_CMD_RDCLR)
                clr_rc = 1'b1;
        end
    end

    assign sup_back = sup_prev & ~(ov_live | uv_live);

    // Set wins over every clear except a wipe (logic supply fault or standby return)
    always_comb
    begin
        next_st = st;
        if (clr_rc || clr_all)
        begin
            next_st.temp_warn = 1'b0;
            next_st.temp_shut = 1'b0;
            next_st.vs_ov = 1'b0;
            next_st.vs_uv = 1'b0;
            next_st.oc = '0;
            next_st.ol = '0;
        end
        if (clr_all || sup_back)
            next_st.pump_low = 1'b0;
        next_st.pump_low = next_st.pump_low | filt[`ACDRV_F_PUMP];
        next_st.vs_ov = next_st.vs_ov | ov_live;
        next_st.vs_uv = next_st.vs_uv | uv_live;
        next_st.temp_warn = next_st.temp_warn | filt[`ACDRV_F_TW];
        next_st.temp_shut = next_st.temp_shut | filt[`ACDRV_F_TSD];
        next_st.oc = next_st.oc | filt[`ACDRV_F_OC +: `ACDRV_NDRV];
        next_st.ol = next_st.ol | filt[`ACDRV_F_OL +: `ACDRV_NDRV];
        if (wipe)
            next_st = '0;
    end

    always_ff @(posedge mclk_i)
    begin
        if (reset_i)
        begin
            mode <= ST_STANDBY;
            stby_cnt <= '0;
            st <= '0;
            sup_prev <= 1'b0;
        end
        else if (ce_i)
        begin
            mode <= next_mode;
            stby_cnt <= next_stby_cnt;
            st <= next_st;
            sup_prev <= ov_live | uv_live;
        end
    end

    // ------------------------------------------------------------------------
    // PWM generator
    // ------------------------------------------------------------------------
    logic [`ACDRV_CNT_W-1:0] pre;
    logic [`ACDRV_CNT_W-1:0] next_pre;
    logic [6:0] phase;
    logic [6:0] next_phase;
    logic [`ACDRV_CNT_W-1:0] step_len;

    always_comb
    begin
        step_len = pwm_fast_i ? `ACDRV_CNT_W'(`ACDRV_PWM_HI_STEP) :
                                `ACDRV_CNT_W'(`ACDRV_PWM_LO_STEP);
        next_pre = pre + `ACDRV_CNT_W'(1);
        next_phase = phase;
        if (pre >= step_len - `ACDRV_CNT_W'(1))
        begin
            next_pre = '0;
            next_phase = phase + 7'h01;
        end
    end

    always_ff @(posedge mclk_i)
    begin
        if (reset_i)
        begin
            pre <= '0;
            phase <= 7'h00;
        end
        else if (ce_i)
        begin
            pre <= next_pre;
            phase <= next_phase;
        end
    end

    // ------------------------------------------------------------------------
    // Driver requests and overcurrent retry
    // ------------------------------------------------------------------------
    logic glob_ok;
    logic sup_off;
    logic [`ACDRV_NDRV-1:0] want;

    assign sup_off = ov_live | uv_live
                   | (supply_fault_recovery_disable_i & (st.vs_ov | st.vs_uv));
    assign glob_ok = mode == ST_ACTIVE && !hold && !sup_off
                   && !st.pump_low && !st.temp_shut;

    for (genvar d = 0; d < `ACDRV_NDRV; d++)
    begin : g_drv
        logic [`ACDRV_CNT_W-1:0] rcnt;
        logic [`ACDRV_CNT_W-1:0] next_rcnt;
        logic ron;
        logic next_ron;
        logic [`ACDRV_CNT_W-1:0] rlen;
        logic req;

        always_comb
        begin
            rlen = `ACDRV_CNT_W'(`ACDRV_US2CYC(`ACDRV_OCREC_ON_US));
            if (!ron)
                rlen = `ACDRV_CNT_W'(`ACDRV_US2CYC(`ACDRV_OCREC_ON_US)
                       * (oc_duty25_i ? `ACDRV_OCREC_OFF25 : `ACDRV_OCREC_OFF12));
            next_rcnt = rcnt + `ACDRV_CNT_W'(1);
            next_ron = ron;
            if (!st.oc[d] || !oc_recovery_i[d])
            begin
                next_rcnt = '0;
                next_ron = 1'b0;
            end
            else if (rcnt >= rlen - `ACDRV_CNT_W'(1))
            begin
                next_rcnt = '0;
                next_ron = ~ron;
            end
            // Open-load and warning flags never reach the driver
            req = on_i[d] & (~pwm_en_i[d] | (phase < duty_i[d % `ACDRV_NPWM]));
            want[d] = req & glob_ok & (~st.oc[d] | ron);
        end

        always_ff @(posedge mclk_i)
        begin
            if (reset_i)
            begin
                rcnt <= '0;
                ron <= 1'b0;
            end
            else if (ce_i)
            begin
                rcnt <= next_rcnt;
                ron <= next_ron;
            end
        end
    end

    // ------------------------------------------------------------------------
    // Half-bridge cross-current sequencing
    // ------------------------------------------------------------------------
    logic [`ACDRV_NDRV-1:0] next_drive;
    logic [2*`ACDRV_NHB-1:0] next_fast;

    for (genvar b = 0; b < `ACDRV_NHB; b++)
    begin : g_hb
        logic [`ACDRV_CNT_W-1:0] dcnt;
        logic [`ACDRV_CNT_W-1:0] next_dcnt;

        always_comb
        begin
            next_dcnt = (dcnt != '0) ? dcnt - `ACDRV_CNT_W'(1) : '0;
            next_drive[2*b] = drive_o[2*b] & want[2*b];
            next_drive[2*b+1] = drive_o[2*b+1] & want[2*b+1];
            if ((drive_o[2*b] & ~want[2*b]) | (drive_o[2*b+1] & ~want[2*b+1]))
                next_dcnt = `ACDRV_CNT_W'(`ACDRV_US2CYC(`ACDRV_CROSS_US));
            else if (dcnt == '0 && !drive_o[2*b] && !drive_o[2*b+1])
            begin
                if (want[2*b])
                    next_drive[2*b] = 1'b1;
                else if (want[2*b+1])
                    next_drive[2*b+1] = 1'b1;
            end
            next_fast[2*b] = ~next_drive[2*b] & (next_dcnt == '0);
            next_fast[2*b+1] = ~next_drive[2*b+1] & (next_dcnt == '0);
        end

        always_ff @(posedge mclk_i)
        begin
            if (reset_i)
                dcnt <= '0;
            else if (ce_i)
                dcnt <= next_dcnt;
        end
    end

    assign next_drive[`ACDRV_NDRV-1:2*`ACDRV_NHB] = want[`ACDRV_NDRV-1:2*`ACDRV_NHB];

    // ------------------------------------------------------------------------
    // Current monitor and outputs
    // ------------------------------------------------------------------------
    logic [`ACDRV_CNT_W-1:0] blank;
    logic [`ACDRV_CNT_W-1:0] next_blank;
    logic next_cm;
    logic cm_src_on;
    acdrv_supply_ctl_type next_ctl;

    always_comb
    begin
        cm_src_on = 1'b0;
        if (current_monitor_select_i < 4'(`ACDRV_NDRV))
            cm_src_on = drive_o[current_monitor_select_i[2:0]];
        next_blank = '0;
        next_cm = 1'b0;
        if (cm_src_on && current_monitor_select_i == current_monitor_source_o)
        begin
            next_blank = blank;
            if (blank >= `ACDRV_CNT_W'(`ACDRV_US2CYC(`ACDRV_BLANK_US)) - `ACDRV_CNT_W'(1))
                next_cm = 1'b1;
            else
                next_blank = blank + `ACDRV_CNT_W'(1);
        end
        next_ctl.pump_en = mode != ST_STANDBY && !hold && !ov_live && !st.temp_shut;
        next_ctl.mirror_en = glob_ok;
        next_ctl.gate_sink = ov_live;
        next_ctl.gate_resistive = mode == ST_STANDBY || st.pump_low || st.temp_shut;
        next_ctl.outputs_hiz = ov_live || uv_live || hold;
    end

    always_ff @(posedge mclk_i)
    begin
        if (reset_i)
        begin
            blank <= '0;
            active_o <= 1'b0;
            drive_o <= '0;
            fast_off_o <= '1;
            supply_ctl_o <= '0;
            status_o <= '0;
            current_monitor_output_o <= 1'b0;
            current_monitor_source_o <= 4'h0;
        end
        else if (ce_i)
        begin
            blank <= next_blank;
            active_o <= next_mode != ST_STANDBY;
            drive_o <= next_drive;
            fast_off_o <= next_fast;
            supply_ctl_o <= next_ctl;
            status_o <= next_st;
            current_monitor_output_o <= next_cm;
            current_monitor_source_o <= current_monitor_select_i;
        end
    end

endmodule // acdrv_core

/* tb/acdrv_asserts.sv */
// Port assertions for acdrv_core, attached by bind.
// Assumes ce_i stays high while the core is exercised.
`timescale 1ns/1ps
module acdrv_asserts
    import acdrv_pkg::*;
#(parameter int STANDBY_CYC = 40)
(
    input wire logic mclk_i,
    input wire logic reset_i,
    input wire logic cs_n_i,
    input wire logic enable_i,
    input wire logic vs_ov_i,
    input wire logic vcc_high_i,
    input wire logic [7:0] on_i,
    input wire logic [7:0] oc_recovery_i,
    input wire logic active_o,
    input wire logic [7:0] drive_o,
    input wire acdrv_supply_ctl_type supply_ctl_o,
    input wire acdrv_status_type status_o,
    input wire logic current_monitor_output_o,
    input wire logic [3:0] current_monitor_source_o
);
    default clocking @(posedge mclk_i); endclocking
    default disable iff (reset_i);
    logic [15:0] idle_cnt;
    logic [7:0] gap_cnt;
    // Idle time awaiting standby, and low time of bridge 0 high side
    always_ff @(posedge mclk_i)
    begin
        idle_cnt <= (reset_i || !(active_o && cs_n_i && !enable_i)) ? 16'h0 : idle_cnt + 16'h1;
        gap_cnt <= reset_i ? 8'hFF : drive_o[0] ? 8'h0 : gap_cnt + {7'h0, gap_cnt != 8'hFF};
    end
    sequence s_off4; (!on_i[4])[*3]; endsequence
    property p_pwm_and; s_off4 |-> !drive_o[4]; endproperty
    a_pwm_and: assert property (p_pwm_and) else $error("drive without on bit");
    property p_oc; status_o.oc[4] && !oc_recovery_i[4] |-> ##[0:2] !drive_o[4]; endproperty
    a_oc: assert property (p_oc) else $error("driver on with overcurrent");
    property p_tsd; status_o.temp_shut |-> ##[0:2] drive_o == 8'h0; endproperty
    a_tsd: assert property (p_tsd) else $error("driver on in shutdown");
    property p_ov; status_o.vs_ov && vs_ov_i |-> ##[0:2] supply_ctl_o.outputs_hiz
        && !supply_ctl_o.pump_en && supply_ctl_o.gate_sink; endproperty
    a_ov: assert property (p_ov) else $error("overvoltage not safe");
    property p_pump; status_o.pump_low |-> ##[0:2] drive_o == 8'h0 && !supply_ctl_o.mirror_en
        && supply_ctl_o.gate_resistive; endproperty
    a_pump: assert property (p_pump) else $error("pump low not safe");
    property p_vcc; vcc_high_i[*3] |-> ##[0:3] status_o == '0 && !active_o; endproperty
    a_vcc: assert property (p_vcc) else $error("logic supply wipe missing");
    property p_cm; $fell(drive_o[4]) && current_monitor_source_o == 4'h4
        |-> ##[0:2] !current_monitor_output_o; endproperty
    a_cm: assert property (p_cm) else $error("monitor on for off output");
    property p_stby; idle_cnt <= STANDBY_CYC + 8; endproperty
    a_stby: assert property (p_stby) else $error("standby return late");
    property p_cross; $rose(drive_o[1]) |-> gap_cnt >= 8'h2D; endproperty
    a_cross: assert property (p_cross) else $error("cross delay short");
    property p_shoot; !(drive_o[0] && drive_o[1]); endproperty
    a_shoot: assert property (p_shoot) else $error("bridge shoot through");
endmodule // acdrv_asserts
bind acdrv_core acdrv_asserts #(.STANDBY_CYC(STANDBY_CYC)) i_asserts (.*);

/* tb/acdrv_host.sv */
// Serial host model: chip select, serial clock and data.
// Assumes the core shifts data in on the rising serial clock.
`timescale 1ns/1ps
module acdrv_host
(
    output logic sclk_o,
    output logic cs_n_o,
    output logic sdi_o
);
    initial
    begin
        sclk_o = 1'h0;
        cs_n_o = 1'h1;
        sdi_o = 1'h0;
    end
    // One byte MSB first; clock idles low, data inverted after release
    task automatic send(input logic [7:0] b, input logic wake);
        cs_n_o = 1'h0;
        if (wake)
            #10000;
        for (int i = 7; i >= 0; i--)
        begin
            sdi_o = b[i];
            #3 sclk_o = 1'h1;
            #3 sclk_o = 1'h0;
        end
        #3 cs_n_o = 1'h1;
        sdi_o = ~b[0];
        #200;
    endtask
endmodule // acdrv_host

/* tb/acdrv_core_tb.sv */
// Self-checking bench for acdrv_core with a serial host model.
// Assumes acdrv_pkg and the defines are compiled first.
`timescale 1ns/1ps
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin fail_count++; \
    $display("ERROR %0t got %h exp %h", $time, a, b); end end
`define WT(c, n) begin k = 0; while (!(c) && k < n) begin @(negedge mclk_i); k++; end \
    if (!(c)) begin fail_count++; conclude(); end end
module acdrv_core_tb
    import acdrv_pkg::*;
;
    logic mclk_i = 1'h0;
    logic reset_i = 1'h1;
    logic ce_i = 1'h1;
    logic sclk_i, cs_n_i, sdi_i, enable_i, supply_fault_recovery_disable_i, oc_duty25_i;
    logic pwm_fast_i, pump_low_i, vs_ov_i, vs_uv_i, temp_warn_i, temp_shut_i, vcc_low_i;
    logic vcc_high_i, active_o, current_monitor_output_o;
    logic [7:0] on_i, pwm_en_i, oc_recovery_i, oc_i, ol_i, drive_o;
    logic [3:0][6:0] duty_i;
    logic [3:0] current_monitor_select_i, current_monitor_source_o, fast_off_o;
    acdrv_supply_ctl_type supply_ctl_o;
    acdrv_status_type status_o;
    int fail_count = 0;
    int tests_run = 0;
    int k;
    always #20 mclk_i = ~mclk_i;
    acdrv_core #(.STANDBY_CYC(40), .OL_FILT_CYC(20)) i_dut (.*);
    acdrv_host i_host (.sclk_o(sclk_i), .cs_n_o(cs_n_i), .sdi_o(sdi_i));
    task automatic tick(input int n);
        repeat (n) @(negedge mclk_i);
    endtask
    task automatic cmd(input logic [7:0] b, input logic wake);
        i_host.send(b, wake);
        tick(1);
    endtask
    task automatic conclude();
        $display("comparisons %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    initial
    begin
        {enable_i, supply_fault_recovery_disable_i, oc_duty25_i, pwm_fast_i} = 4'h0;
        {pump_low_i, vs_ov_i, vs_uv_i, temp_warn_i, temp_shut_i, vcc_low_i, vcc_high_i} = 7'h0;
        {on_i, pwm_en_i, oc_recovery_i, oc_i, ol_i} = 40'h0;
        duty_i = 28'h0;
        current_monitor_select_i = 4'h4;
        tick(8);
        reset_i = 1'h0;
        tick(1);
        `CHK({active_o, drive_o, status_o}, 30'h0)
        cmd(8'h00, 1'h1);
        `CHK(active_o, 1'h1)
        tick(30);
        `CHK(active_o, 1'h1)
        `WT(!active_o, 30)
        $display("standby test end");
        {enable_i, pwm_fast_i} = 2'h3;
        cmd(8'hC0, 1'h1);
        {on_i, pwm_en_i} = 16'h1010;
        tick(5);
        `CHK(drive_o[4], 1'h0)
        duty_i[0] = 7'h7F;
        tick(3);
        `CHK(drive_o[4], 1'h1)
        `WT(current_monitor_output_o, 600)
        `CHK(current_monitor_source_o, 4'h4)
        oc_i = 8'h10;
        tick(20);
        oc_i = 8'h0;
        tick(5);
        `CHK({status_o.oc, drive_o[4]}, 9'h1)
        oc_i = 8'h10;
        `WT(status_o.oc[4], 100)
        tick(3);
        `CHK({drive_o[4], current_monitor_output_o}, 2'h0)
        oc_i = 8'h0;
        tick(20);
        `CHK(drive_o[4], 1'h0)
        oc_recovery_i = 8'h10;
        tick(1700);
        `CHK(drive_o[4], 1'h0)
        `WT(drive_o[4], 100)
        `CHK(status_o.oc[4], 1'h1)
        oc_recovery_i = 8'h0;
        cmd(8'hC0, 1'h0);
        `WT(drive_o[4], 20)
        ol_i = 8'h10;
        `WT(status_o.ol[4], 60)
        tick(2);
        `CHK(drive_o[4], 1'h1)
        ol_i = 8'h0;
        $display("driver test end");
        vs_ov_i = 1'h1;
        `WT(status_o.vs_ov, 700)
        tick(3);
        `CHK({supply_ctl_o.pump_en, supply_ctl_o.gate_sink, supply_ctl_o.outputs_hiz}, 3'h3)
        vs_ov_i = 1'h0;
        `WT(!supply_ctl_o.outputs_hiz, 50)
        tick(3);
        `CHK(drive_o[4], 1'h1)
        supply_fault_recovery_disable_i = 1'h1;
        vs_uv_i = 1'h1;
        `WT(status_o.vs_uv, 700)
        tick(3);
        `CHK(supply_ctl_o.outputs_hiz, 1'h1)
        vs_uv_i = 1'h0;
        tick(50);
        `CHK(drive_o[4], 1'h0)
        cmd(8'hC3, 1'h0);
        `WT(drive_o[4], 20)
        $display("supply test end");
        {temp_warn_i, temp_shut_i} = 2'h3;
        `WT(status_o.temp_shut, 1300)
        tick(3);
        `CHK({status_o.temp_warn, drive_o}, 9'h100)
        {temp_warn_i, temp_shut_i} = 2'h0;
        cmd(8'hD5, 1'h0);
        `WT(drive_o[4], 20)
        `CHK({status_o.temp_warn, status_o.temp_shut}, 2'h0)
        pump_low_i = 1'h1;
        `WT(status_o.pump_low, 1500)
        tick(3);
        `CHK({drive_o, supply_ctl_o.mirror_en, supply_ctl_o.gate_resistive}, 10'h1)
        pump_low_i = 1'h0;
        cmd(8'hE7, 1'h0);
        `CHK(status_o.pump_low, 1'h1)
        cmd(8'hFF, 1'h0);
        `WT(drive_o[4], 20)
        `CHK(status_o.pump_low, 1'h0)
        $display("protection test end");
        on_i = 8'h11;
        `WT(drive_o[0], 60)
        ce_i = 1'h0;
        on_i = 8'h12;
        tick(30);
        `CHK(drive_o[1:0], 2'h1)
        ce_i = 1'h1;
        tick(30);
        `CHK({fast_off_o[0], drive_o[1:0]}, 3'h0)
        `WT(drive_o[1], 60)
        `CHK(fast_off_o[0], 1'h1)
        ol_i = 8'h10;
        `WT(status_o.ol[4], 60)
        vcc_high_i = 1'h1;
        tick(6);
        `CHK({active_o, drive_o, status_o}, 30'h0)
        $display("bridge and reset test end");
        conclude();
    end
endmodule // acdrv_core_tb
